// ===== logic/pmwg_guard.sv
// Purpose: program memory write guard with apb configuration port
// Assumes: requests are synchronous to pclk, one cycle per request
// Notes:   allow outputs are combinational, status comes from flops
//
// Contract
// - code protect refuses external reads and writes
// - write protect low blocks internal writes
// - segment hit withholds the safety interlock
// - segment protection only adds to global
// - segment enabled only when disable is zero
// - boundary page itself always protected
// - bottom mode protects zero through page
// - top mode protects page through end
// - last-page lock zero protects final page
// - disabled segment adds no protection
// - end zero, lock one protects upward
// - complementary shadow compared with live copy
// - mismatch raises parity error and reset
// - code protect also guards configuration words
//
// The APB register port and the address map were chosen for this implementation.

`timescale 1ns/1ns

module pmwg_guard #(
   parameter int NUM_PAGES = 64
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [pmwg_pkg::PADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire pmwg_pkg::pmwg_req_t          nvm_req,
   output logic                              nvm_allow,
   output logic                              nvm_interlock_en,
   input  wire pmwg_pkg::pmwg_ext_t          ext_req,
   output logic                              ext_allow,
   output logic                              device_reset_req
);
   import pmwg_pkg::*;

   localparam logic [PAGE_W-1:0] LAST_PG = PAGE_W'(NUM_PAGES - 1);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
      page_of = a[ADDR_W-1:PAGE_BITS];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = m;
   endfunction

   function automatic logic seg_hit(input pmwg_cfg_t c,
                                    input logic [PAGE_W-1:0] pg);
      logic [PAGE_W-1:0] fp;
      logic              up;
      fp = {{(PAGE_W-FP_W){1'b0}}, c.boundary_page_select};
      up = c.segment_end_select | c.last_page_lock;
      seg_hit = 1'b0;
      if (!c.segment_protect_disable) begin
         if (up) begin
            seg_hit = (pg >= fp);
         end else begin
            seg_hit = (pg <= fp);
         end
      end
      if (!c.last_page_lock && pg == LAST_PG) begin
         seg_hit = 1'b1;
      end
   endfunction

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic        acc;
   logic        wr;
   logic        addr_ok;
   logic [31:0] wmerge;
   logic [31:0] smerge;

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign addr_ok = (paddr == OFF_CFG) | (paddr == OFF_SHADOW) |
                    (paddr == OFF_STATUS) | (paddr == OFF_DENYCT) |
                    (paddr == OFF_DENYAD);
   assign pready  = 1'b1;
   assign pslverr = acc & ~addr_ok;

   // ---------------------------------------------------------------
   // configuration and shadow
   // ---------------------------------------------------------------
   pmwg_cfg_t          cfg_r;
   logic [CFG_W-1:0]   shadow_r;
   logic               mismatch;

   assign wmerge = merge({21'h0, cfg_r}, pwdata, pstrb);
   assign smerge = merge({21'h0, shadow_r}, pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= CFG_RST;
      end else if (wr && paddr == OFF_CFG) begin
         cfg_r <= wmerge[CFG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_r <= ~CFG_RST;
      end else if (wr && paddr == OFF_CFG) begin
         shadow_r <= ~wmerge[CFG_W-1:0];
      end else if (wr && paddr == OFF_SHADOW) begin
         shadow_r <= smerge[CFG_W-1:0];
      end
   end

   assign mismatch = (cfg_r != ~shadow_r);

   // ---------------------------------------------------------------
   // parity error and device reset
   // ---------------------------------------------------------------
   logic par_r;
   logic rst_req_r;
   logic clr_wr;

   assign clr_wr = wr && paddr == OFF_STATUS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_r <= 1'b0;
      end else begin
         par_r <= mismatch | (par_r & ~(clr_wr & pwdata[ST_PARITY] & pstrb[0]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_req_r <= 1'b0;
      end else begin
         rst_req_r <= mismatch;
      end
   end

   assign device_reset_req = rst_req_r;

   // ---------------------------------------------------------------
   // guard decision
   // ---------------------------------------------------------------
   logic [PAGE_W-1:0] req_pg;
   logic              gcp_on;
   logic              glob_blk;
   logic              seg_blk;

   assign req_pg = page_of(nvm_req.addr);
   assign gcp_on = ~cfg_r.global_code_protect;

   assign glob_blk = ~cfg_r.global_write_protect | (gcp_on & req_pg == LAST_PG);

   assign seg_blk = seg_hit(cfg_r, req_pg);

   assign nvm_allow = ~(glob_blk | seg_blk | mismatch | (req_pg > LAST_PG));

   assign nvm_interlock_en = nvm_req.valid & nvm_allow;

   assign ext_allow = ~gcp_on & ~mismatch;

   // ---------------------------------------------------------------
   // status record
   // ---------------------------------------------------------------
   logic              deny_r;
   logic              extref_r;
   logic [CNT_W-1:0]  deny_cnt_r;
   logic [ADDR_W-1:0] deny_addr_r;
   logic              denied;
   logic              ext_ref;

   assign denied  = nvm_req.valid & ~nvm_allow;
   assign ext_ref = ext_req.valid & ~ext_allow;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deny_r <= 1'b0;
      end else begin
         deny_r <= denied | (deny_r & ~(clr_wr & pwdata[ST_DENY] & pstrb[0]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extref_r <= 1'b0;
      end else begin
         extref_r <= ext_ref | (extref_r & ~(clr_wr & pwdata[ST_EXTREF] & pstrb[0]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deny_cnt_r <= '0;
      end else if (denied && deny_cnt_r != {CNT_W{1'b1}}) begin
         deny_cnt_r <= deny_cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deny_addr_r <= '0;
      end else if (denied) begin
         deny_addr_r <= nvm_req.addr;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFF_CFG:    prdata <= {21'h0, cfg_r};
            OFF_SHADOW: prdata <= {21'h0, shadow_r};
            OFF_STATUS: prdata <= {28'h0, mismatch, extref_r, deny_r, par_r};
            OFF_DENYCT: prdata <= {16'h0, deny_cnt_r};
            OFF_DENYAD: prdata <= {8'h0, deny_addr_r};
            default:    prdata <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [PAGE_W-1:0] fp_pg;
   assign fp_pg = {{(PAGE_W-FP_W){1'b0}}, cfg_r.boundary_page_select};

   sequence s_cfg_write;
      wr && paddr == OFF_CFG;
   endsequence

   sequence s_mism;
      mismatch;
   endsequence

   chk_ext_code_refuse: assert property (
      gcp_on && ext_req.valid |-> !ext_allow ##1 extref_r)
      else $error("external access passed under code protect");

   chk_write_prot_all: assert property (
      !cfg_r.global_write_protect && nvm_req.valid |-> !nvm_interlock_en ##1 deny_r)
      else $error("internal write passed under write protect");

   chk_seg_bottom: assert property (
      !cfg_r.segment_protect_disable && !cfg_r.segment_end_select &&
      !cfg_r.last_page_lock && req_pg <= fp_pg && nvm_req.valid
      |-> !nvm_interlock_en)
      else $error("bottom segment write passed");

   chk_seg_top: assert property (
      !cfg_r.segment_protect_disable && cfg_r.segment_end_select &&
      req_pg >= fp_pg && nvm_req.valid |-> !nvm_interlock_en)
      else $error("top segment write passed");

   chk_seg_upward_alt: assert property (
      !cfg_r.segment_protect_disable && !cfg_r.segment_end_select &&
      cfg_r.last_page_lock && nvm_req.valid
      |-> nvm_interlock_en == (req_pg < fp_pg && req_pg != LAST_PG && !glob_blk && !mismatch))
      else $error("end zero lock one range wrong");

   chk_last_page_lock: assert property (
      !cfg_r.last_page_lock && req_pg == LAST_PG && nvm_req.valid |-> !nvm_interlock_en)
      else $error("last page write passed under lock");

   chk_no_extra_prot: assert property (
      cfg_r.segment_protect_disable && cfg_r.last_page_lock &&
      cfg_r.global_write_protect && !gcp_on && !mismatch &&
      req_pg <= LAST_PG && nvm_req.valid |-> nvm_interlock_en)
      else $error("write refused with no protection set");

   chk_cfg_word_gcp: assert property (
      gcp_on && req_pg == LAST_PG && nvm_req.valid |-> !nvm_interlock_en)
      else $error("configuration words written under code protect");

   chk_shadow_follow: assert property (
      s_cfg_write |=> (shadow_r == ~cfg_r) && !mismatch)
      else $error("shadow not complement after write");

   chk_parity_reset: assert property (
      s_mism |=> device_reset_req && par_r)
      else $error("mismatch without parity reset");

   chk_deny_count: assert property (
      denied && deny_cnt_r != {CNT_W{1'b1}}
      |=> deny_cnt_r == $past(deny_cnt_r) + CNT_W'(1) && deny_addr_r == $past(nvm_req.addr))
      else $error("denied request not recorded");

   chk_idle_no_lock: assert property (
      !nvm_req.valid |-> !nvm_interlock_en)
      else $error("interlock without request");

   chk_parity_sticky: assert property (
      par_r && !mismatch && !(clr_wr && pwdata[ST_PARITY] && pstrb[0]) |=> par_r)
      else $error("parity flag lost without clear");

   chk_mism_deny_all: assert property (
      mismatch |-> !nvm_allow && !ext_allow)
      else $error("access allowed during mismatch");

   chk_reset_clears: assert property (
      !mismatch |=> !device_reset_req)
      else $error("device reset without mismatch");

endmodule

// ===== logic/pmwg_pkg.sv
// Purpose: shared constants and types of the program memory write guard
// Assumes: word addressed program memory, 512-word pages
// Notes:   register offsets are byte addresses on the apb slave

package pmwg_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W    = 24;
   localparam int PAGE_BITS = 9;
   localparam int FP_W      = 6;
   localparam int PAGE_W    = ADDR_W - PAGE_BITS;
   localparam int CFG_W     = 11;
   localparam int CNT_W     = 16;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int          PADDR_W    = 12;
   localparam logic [11:0] OFF_CFG    = 12'h000;
   localparam logic [11:0] OFF_SHADOW = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_DENYCT = 12'h00C;
   localparam logic [11:0] OFF_DENYAD = 12'h010;

   // status bits
   localparam int ST_PARITY = 0;
   localparam int ST_DENY   = 1;
   localparam int ST_EXTREF = 2;
   localparam int ST_MISM   = 3;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FP_W-1:0] boundary_page_select;
      logic            last_page_lock;
      logic            segment_end_select;
      logic            segment_protect_disable;
      logic            global_write_protect;
      logic            global_code_protect;
   } pmwg_cfg_t;

   // unprogrammed: every protection off
   localparam pmwg_cfg_t CFG_RST = 11'h7FF;

   typedef struct packed {
      logic              valid;
      logic              erase;
      logic [ADDR_W-1:0] addr;
   } pmwg_req_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
   } pmwg_ext_t;

endpackage

// ===== sim/pmwg_seq_model.sv
// Purpose: write and erase sequencer and external programmer model
// Assumes: one request per command pulse, lines scrambled when idle
// Notes:   counts commits so that denied requests can be proven inert

`timescale 1ns/1ns

module pmwg_seq_model (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        cmd_go,
   input  wire logic                        cmd_erase,
   input  wire logic [pmwg_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic                        interlock_en,
   output pmwg_pkg::pmwg_req_t              nvm_req,
   output pmwg_pkg::pmwg_ext_t              ext_req,
   output int                               mem_writes
);
   import pmwg_pkg::*;

   // ---------------------------------------------------------------
   // request lines
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvm_req <= '0;
         ext_req <= '0;
      end else if (cmd_go) begin
         nvm_req <= {1'b1, cmd_erase, cmd_addr};
         ext_req <= {1'b1, ~cmd_erase, cmd_addr};
      end else begin
         nvm_req <= {1'b0, ~nvm_req.erase, ~nvm_req.addr};
         ext_req <= {1'b0, ~ext_req.write, ~ext_req.addr};
      end
   end

   // ---------------------------------------------------------------
   // memory commits
   // ---------------------------------------------------------------
   // commit only when enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_writes <= 0;
      end else if (interlock_en) begin
         mem_writes <= mem_writes + 1;
      end
   end
endmodule

// ===== sim/pmwg_guard_test.sv
// Purpose: self-checking bench of the program memory write guard
// Assumes: zero wait state apb slave, 64 pages
// Notes:   expected results queue up, a monitor compares them

`timescale 1ns/1ns

module pmwg_guard_test;
   import pmwg_pkg::*;

   localparam int LAST_PG = 63;

   logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [PADDR_W-1:0]  paddr = '0;
   logic [31:0]         pwdata = '0, prdata;
   logic                pready, pslverr, nvm_allow, interlock_en, ext_allow, rst_req;
   logic                cmd_go = 0, cmd_erase = 0;
   logic [ADDR_W-1:0]   cmd_addr = '0, daddr = '0;
   pmwg_req_t           nvm_req;
   pmwg_ext_t           ext_req;
   pmwg_cfg_t           cfg_q = CFG_RST;
   int                  mem_writes, failures = 0, n_checks = 0, dcnt = 0, nwr = 0, fp;
   logic                mism = 0, ext_ref = 0;
   logic [32:0]         apb_q[$];
   logic [3:0]          pstrb = 4'hF;
   logic [32:0]         ae;
   logic [2:0]          ne;
   logic [2:0]          nvm_q[$];

   always #10 pclk = ~pclk;

   pmwg_guard #(.NUM_PAGES(64)) u_pmwg_guard (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nvm_req(nvm_req), .nvm_allow(nvm_allow),
      .nvm_interlock_en(interlock_en), .ext_req(ext_req), .ext_allow(ext_allow),
      .device_reset_req(rst_req));

   pmwg_seq_model u_pmwg_seq_model (
      .pclk(pclk), .presetn(presetn), .cmd_go(cmd_go), .cmd_erase(cmd_erase),
      .cmd_addr(cmd_addr), .interlock_en(interlock_en), .nvm_req(nvm_req),
      .ext_req(ext_req), .mem_writes(mem_writes));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic print_verdict();
      if (failures == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [2:0] expect_res(pmwg_cfg_t c, logic mm, int pg);
      logic seg;
      logic dn;
      seg = c.segment_end_select | c.last_page_lock ? pg >= c.boundary_page_select
            : pg <= c.boundary_page_select;
      dn = mm | !c.global_write_protect | (!c.segment_protect_disable && seg)
           | (pg == LAST_PG && !(c.global_code_protect && c.last_page_lock));
      return {mm, c.global_code_protect & !mm, !dn};
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      n = 0;
      if (!wr) apb_q.push_back(e);
      psel    <= 1;
      penable <= 0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) begin
         failures++;
         print_verdict();
      end
      psel    <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask

   task automatic nvm_op(input int pg);
      logic [ADDR_W-1:0] a;
      logic [2:0]        e;
      a = {PAGE_W'(pg), PAGE_BITS'($urandom())};
      e = expect_res(cfg_q, mism, pg);
      nvm_q.push_back(e);
      if (!e[0]) begin
         dcnt++;
         daddr = a;
      end else nwr++;
      if (!e[1]) ext_ref = 1;
      cmd_addr  <= a;
      cmd_erase <= 1'($urandom());
      cmd_go    <= 1;
      @(posedge pclk);
      cmd_go <= 0;
      @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // monitor
   // ---------------------------------------------------------------
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready && !pwrite) begin
         ae = apb_q.size() ? apb_q.pop_front() : 'x;
         check("apb_read", {pslverr, prdata}, ae);
      end
      if (presetn && nvm_req.valid) begin
         ne = nvm_q.size() ? nvm_q.pop_front() : 'x;
         check("nvm_result", {rst_req, ext_allow, interlock_en}, ne);
         check("nvm_allow", 33'(nvm_allow), 33'(ne[0]));
      end
   end

   initial begin
      #1000000;
      failures++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h76F69A2A));
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, OFF_CFG, 32'h0, {1'b0, 32'h0000_07FF});
      apb(0, OFF_SHADOW, 32'h0, 33'h0);
      apb(0, OFF_STATUS, 32'h0, 33'h0);
      for (int m = 0; m < 32; m++) begin
         fp    = 1 + $urandom_range(61);
         cfg_q = pmwg_cfg_t'({fp[5:0], m[4:0]});
         apb(1, OFF_CFG, {21'h0, cfg_q}, '0);
         nvm_op(0);
         nvm_op(fp - 1);
         nvm_op(fp);
         nvm_op(fp + 1);
         nvm_op(LAST_PG);
         nvm_op($urandom_range(LAST_PG));
      end
      apb(0, OFF_STATUS, 32'h0, {30'h0, ext_ref, 2'b10});
      apb(0, OFF_DENYCT, 32'h0, {17'h0, dcnt[15:0]});
      apb(1, OFF_DENYCT, 32'h0, '0);
      apb(0, OFF_DENYCT, 32'h0, {17'h0, dcnt[15:0]});
      apb(0, OFF_DENYAD, 32'h0, {9'h0, daddr});
      apb(1, OFF_STATUS, 32'h7, '0);
      apb(0, OFF_STATUS, 32'h0, 33'h0);
      apb(1, 12'h020, 32'hFFFF_FFFF, '0);
      apb(0, 12'h020, 32'h0, {1'b1, 32'h0});
      pstrb <= 4'h2;
      apb(1, OFF_CFG, 32'h0, '0);
      pstrb <= 4'hF;
      apb(0, OFF_CFG, 32'h0, {25'h0, cfg_q[7:0]});
      cfg_q = CFG_RST;
      apb(1, OFF_CFG, 32'h0000_07FF, '0);
      apb(1, OFF_SHADOW, 32'h0000_0001, '0);
      mism = 1;
      nvm_op(5);
      apb(0, OFF_STATUS, 32'h0, 33'h0_0000_000F);
      apb(1, OFF_SHADOW, 32'h0, '0);
      mism = 0;
      apb(1, OFF_STATUS, 32'hF, '0);
      apb(0, OFF_STATUS, 32'h0, 33'h0);
      nvm_op(5);
      repeat (3) @(posedge pclk);
      check("mem_writes", 33'(mem_writes), 33'(nwr));
      print_verdict();
   end
endmodule
